// [core/pio_mux_reset_straps.v]
// programmable pin mux with reset synchroniser and strap latch
// Notes on behaviour
// - thirty-two independently configurable pins
// - each pin: enable, direction, pull select
// - power-on pulls and normal pins as documented
// - top address pins stay normal after reset
// - direction, enable, ready pins stay normal
// - address, direction, enable pins offer pull-up
// - ready pin as programmable_io offers pull-down
// - ready forced low while pin is programmable
// - strap low locks pins 26, 29 normal
// - strap high: gate bus by region bits
// - strap low: bus always muxed, bits ignored
// - strap sampled within three clocks after release
// - latched strap modes held until reset
// - reset stops all, clears, vectors boot address
// - reset pin synchronised internally
// - fetch begins seven clocks after internal reset release (6.5 rounded up)
`include "pio_map.vh"
`timescale 1ns/1ps
`default_nettype none

module pio_mux_reset_straps #(
  parameter NPINS = 32
) (
  input wire clk,
  input wire rst,
  // wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // board side reset and strap
  input wire external_clear_pin_n,
  input wire address_enable_strap,
  // pads
  input wire [NPINS-1:0] pad_in,
  output wire [NPINS-1:0] pad_out,
  output wire [NPINS-1:0] pad_oe_n,
  output wire [NPINS-1:0] pad_pull_up,
  output wire [NPINS-1:0] pad_pull_down,
  // peripheral side of each pin
  input wire [NPINS-1:0] periph_out,
  input wire [NPINS-1:0] periph_oe,
  output wire [NPINS-1:0] periph_in,
  // bus phase information from the bus unit
  input wire addr_phase,
  input wire lower_memory_select,
  input wire upper_memory_select,
  output wire muxed_bus_addr_drive,
  // ready path
  input wire sync_ready_input,
  output wire sync_ready_internal,
  // core reset and fetch start
  output wire core_reset,
  output wire fetch_enable,
  output wire fetch_start,
  output wire [19:0] reset_vector
);

  // byte lane merge for writes
  function [31:0] merge_sel;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] sel;
    integer i;
    begin
      merge_sel = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge_sel[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  reg clr_meta_reg;
  reg clr_sync_reg;
  reg [3:0] post_cnt_reg;
  reg [3:0] post_cnt_next;
  reg strap_latched_reg;
  reg strap_value_reg;
  reg fetch_en_reg;
  reg fetch_start_reg;
  reg [31:0] mode_reg;
  reg [31:0] dir_reg;
  reg [31:0] pull_reg;
  reg [31:0] dout_reg;
  reg [1:0] region_reg;
  reg ack_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  reg [NPINS-1:0] pad_out_reg;
  reg [NPINS-1:0] pad_oe_n_reg;
  reg [NPINS-1:0] pull_up_reg;
  reg [NPINS-1:0] pull_dn_reg;
  reg [NPINS-1:0] pin_in_reg;
  reg bus_drive_reg;
  reg ready_reg;
  wire int_rst;
  wire strap_low;
  wire wb_req;
  wire wb_wr;
  wire [31:0] mode_eff;
  wire [31:0] dir_eff;
  wire [31:0] pull_eff;

  // two-flop synchroniser on the reset pin
  always @(posedge clk) begin
    if (rst) begin
      clr_meta_reg <= 1'b0;
      clr_sync_reg <= 1'b0;
    end else begin
      clr_meta_reg <= external_clear_pin_n;
      clr_sync_reg <= clr_meta_reg;
    end
  end

  // internal reset while either source asserted
  assign int_rst = rst | ~clr_sync_reg;

  // cycles since release, saturating
  always @* begin
    post_cnt_next = post_cnt_reg;
    if (post_cnt_reg != `CNT_MAX) begin
      post_cnt_next = post_cnt_reg + 4'h1;
    end
  end

  always @(posedge clk) begin
    if (int_rst) begin
      post_cnt_reg <= 4'h0;
    end else begin
      post_cnt_reg <= post_cnt_next;
    end
  end

  // strap latch, held until the next reset
  always @(posedge clk) begin
    if (int_rst) begin
      strap_latched_reg <= 1'b0;
      strap_value_reg <= 1'b1;
    end else if (!strap_latched_reg &&
                 post_cnt_reg == `STRAP_SAMPLE_CYC) begin
      strap_latched_reg <= 1'b1;
      strap_value_reg <= address_enable_strap;
    end
  end

  // low strap means locked pins and plain muxed bus
  assign strap_low = strap_latched_reg & ~strap_value_reg;

  // fetch enable after the release delay
  always @(posedge clk) begin
    if (int_rst) begin
      fetch_en_reg <= 1'b0;
      fetch_start_reg <= 1'b0;
    end else begin
      fetch_start_reg <= 1'b0;
      if (!fetch_en_reg &&
          post_cnt_reg == `FETCH_DELAY_CYC - 1) begin
        fetch_en_reg <= 1'b1;
        fetch_start_reg <= 1'b1;
      end
    end
  end

  // wishbone decode
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wb_wr = wb_req & wb_we_i;

  // configuration registers, loaded with their reset values by any reset
  always @(posedge clk) begin
    if (int_rst) begin
      mode_reg <= `MODE_RST;
      dir_reg <= `DIR_RST;
      pull_reg <= `PULL_RST;
      dout_reg <= `DOUT_RST;
      region_reg <= 2'b00;
    end else if (wb_wr) begin
      if (wb_adr_i == `OFS_MODE) begin
        mode_reg <= merge_sel(mode_reg, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `OFS_DIR) begin
        dir_reg <= merge_sel(dir_reg, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `OFS_PULL) begin
        pull_reg <= merge_sel(pull_reg, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `OFS_DOUT) begin
        dout_reg <= merge_sel(dout_reg, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `OFS_REGION) begin
        if (wb_sel_i[0] && !strap_low) begin
          region_reg <= wb_dat_i[1:0];
        end else if (wb_sel_i[0]) begin
          region_reg <= 2'b00;
        end
      end
    end
  end

  // effective settings after strap lock and fixed pulls
  assign mode_eff = strap_low ?
                    (mode_reg & ~`STRAP_LOCK_MASK) : mode_reg;
  assign dir_eff = strap_low ?
                   (dir_reg & ~`STRAP_LOCK_MASK) : dir_reg;
  assign pull_eff = (pull_reg & ~`FORCE_MASK) |
                    `FORCE_UP_MASK;

  // read mux
  always @* begin
    rdata_next = 32'h0000_0000;
    if (wb_adr_i == `OFS_MODE) begin
      rdata_next = mode_eff;
    end else if (wb_adr_i == `OFS_DIR) begin
      rdata_next = dir_eff;
    end else if (wb_adr_i == `OFS_PULL) begin
      rdata_next = pull_eff;
    end else if (wb_adr_i == `OFS_DOUT) begin
      rdata_next = dout_reg;
    end else if (wb_adr_i == `OFS_PINS) begin
      rdata_next = pin_in_reg;
    end else if (wb_adr_i == `OFS_REGION) begin
      rdata_next[1:0] = region_reg;
    end else if (wb_adr_i == `OFS_STATUS) begin
      rdata_next[`ST_LATCHED_BIT] = strap_latched_reg;
      rdata_next[`ST_STRAP_BIT] = strap_value_reg;
      rdata_next[`ST_FETCH_BIT] = fetch_en_reg;
    end
  end

  // ack one cycle after request, dropped the next
  always @(posedge clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req;
      if (wb_req) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // per-pin pad drive, registered
  always @(posedge clk) begin
    if (int_rst) begin
      pad_out_reg <= {NPINS{1'b0}};
      pad_oe_n_reg <= {NPINS{1'b1}};
      pull_up_reg <= {NPINS{1'b0}};
      pull_dn_reg <= {NPINS{1'b0}};
      pin_in_reg <= {NPINS{1'b0}};
    end else begin
      pin_in_reg <= pad_in;
      pad_out_reg <= (mode_eff & dout_reg) |
                     (~mode_eff & periph_out);
      pad_oe_n_reg <= ~((mode_eff & dir_eff) |
                        (~mode_eff & periph_oe));
      pull_up_reg <= mode_eff & ~dir_eff & pull_eff;
      pull_dn_reg <= mode_eff & ~dir_eff & ~pull_eff;
    end
  end

  assign pad_out = pad_out_reg;
  assign pad_oe_n = pad_oe_n_reg;
  assign pad_pull_up = pull_up_reg;
  assign pad_pull_down = pull_dn_reg;
  assign periph_in = pad_in;

  // address phase gating and ready forcing
  always @(posedge clk) begin
    if (int_rst) begin
      bus_drive_reg <= 1'b1;
      ready_reg <= 1'b0;
    end else begin
      bus_drive_reg <= strap_low | ~(addr_phase &
        ((lower_memory_select & region_reg[`REG_LOWER_BIT]) |
         (upper_memory_select &
          region_reg[`REG_UPPER_BIT])));
      ready_reg <= sync_ready_input &
                   ~mode_eff[`SYNC_READY_INPUT_BIT];
    end
  end

  assign muxed_bus_addr_drive = bus_drive_reg;
  assign sync_ready_internal = ready_reg;
  assign core_reset = int_rst;
  assign fetch_enable = fetch_en_reg;
  assign fetch_start = fetch_start_reg;
  assign reset_vector = `RESET_VECTOR;

endmodule // pio_mux_reset_straps

`default_nettype wire

// [core/pio_map.vh]
// register map, reset values and timing constants for the pin mux block
`ifndef PIO_MAP_VH
`define PIO_MAP_VH

// register byte offsets
`define OFS_MODE 8'h00
`define OFS_DIR 8'h04
`define OFS_PULL 8'h08
`define OFS_DOUT 8'h0C
`define OFS_PINS 8'h10
`define OFS_REGION 8'h14
`define OFS_STATUS 8'h18

// power-on values: pins 4..9 normal, pull-down on 1, 10, 22, 23
`define MODE_RST 32'hFFFF_FC0F
`define DIR_RST 32'h0000_0000
`define PULL_RST 32'hFF3F_FBFD
`define DOUT_RST 32'h0000_0000

// pins whose pull is fixed when used as programmable_io
`define FORCE_UP_MASK 32'h0000_03B0
`define FORCE_DN_MASK 32'h0000_0040
`define FORCE_MASK 32'h0000_03F0
// pins kept normal when the address_enable_strap is low
`define STRAP_LOCK_MASK 32'h2400_0000
// sync_ready_input pin index
`define SYNC_READY_INPUT_BIT 6

// region config bits
`define REG_LOWER_BIT 0
`define REG_UPPER_BIT 1
// status bits
`define ST_LATCHED_BIT 0
`define ST_STRAP_BIT 1
`define ST_FETCH_BIT 2

// boot vector
`define RESET_VECTOR 20'hF_FFF0

// timing, clock 100 MHz
`define CLK_PERIOD_NS 10
`define RESET_HOLD_MS 1
`define STRAP_WINDOW_CYC 3
// latch on the first edge out of internal reset, third after the pin rises
`define STRAP_SAMPLE_CYC 4'h0
`define FETCH_DELAY_TENTHS 65
`define FETCH_DELAY_CYC ((`FETCH_DELAY_TENTHS + 9) / 10)
`define CNT_MAX 4'hF

`endif

// [dv/pio_monitor.sv]
// port assertions for the pin mux block
`timescale 1ns/1ps
`default_nettype none
module pio_monitor (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire external_clear_pin_n,
  input wire addr_phase,
  input wire lower_memory_select,
  input wire upper_memory_select,
  input wire muxed_bus_addr_drive,
  input wire sync_ready_input,
  input wire sync_ready_internal,
  input wire core_reset,
  input wire fetch_enable,
  input wire fetch_start,
  input wire [19:0] reset_vector,
  input wire [31:0] pad_oe_n
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // request accepted, reset seen twice
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_held; core_reset ##1 core_reset; endsequence
  property p_ack; s_take |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ack_drop; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack too long");
  property p_vec; reset_vector == 20'hF_FFF0; endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  property p_sync; !external_clear_pin_n [*3] |-> core_reset; endproperty
  a_sync: assert property (p_sync) else $error("pin not synced");
  property p_clear; s_held |-> !fetch_enable && (&pad_oe_n); endproperty
  a_clear: assert property (p_clear) else $error("reset not clean");
  property p_fetch;
    $fell(core_reset) |-> !fetch_start [*5] ##[1:3] fetch_start;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch late");
  property p_pulse; fetch_start |=> !fetch_start && fetch_enable; endproperty
  a_pulse: assert property (p_pulse) else $error("fetch pulse");
  property p_bus;
    !(addr_phase && (lower_memory_select || upper_memory_select))
      |=> muxed_bus_addr_drive;
  endproperty
  a_bus: assert property (p_bus) else $error("bus gated");
  property p_rdy; !sync_ready_input |=> !sync_ready_internal; endproperty
  a_rdy: assert property (p_rdy) else $error("ready high");
endmodule // pio_monitor
bind pio_mux_reset_straps pio_monitor i_pio_monitor (.clk, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .external_clear_pin_n, .addr_phase,
  .lower_memory_select, .upper_memory_select, .muxed_bus_addr_drive,
  .sync_ready_input, .sync_ready_internal, .core_reset, .fetch_enable,
  .fetch_start, .reset_vector, .pad_oe_n);
`default_nettype wire

// [dv/board_model.sv]
// board: reset circuit and devices on the pads
`timescale 1ns/1ps
`default_nettype none
module board_model #(
  parameter int HOLD_CYC = 8
) (
  input wire logic clk,
  input wire logic hold_req,
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_val,
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe_n,
  input wire logic [31:0] pad_pull_up,
  input wire logic [31:0] pad_pull_down,
  output logic external_clear_pin_n,
  output wire logic [31:0] pad_in
);
  int cnt = 0;
  logic [31:0] flt = 32'h0000_0000;
  logic [31:0] drv;
  // reset pin low for a fixed hold, clock keeps running
  always @(posedge clk) cnt <= hold_req ? HOLD_CYC : (cnt > 0 ? cnt - 1 : 0);
  assign external_clear_pin_n = (cnt == 0);
  // undriven unpulled pad toggles
  always @(posedge clk) flt <= ~flt;
  // pin 29 never pulled low by the board while in reset
  assign drv = ext_en & ~{2'b00, ~external_clear_pin_n, 29'h0};
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & drv & ext_val)
    | (pad_oe_n & ~drv & (pad_pull_up | (~pad_pull_down & flt)));
endmodule // board_model
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the pin mux block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, hold = 0;
  logic address_enable_strap = 1, addr_phase = 0, sync_ready_input = 0;
  logic lower_memory_select = 0, upper_memory_select = 0, sl;
  logic [7:0] wb_adr_i = 0, a;
  logic [3:0] wb_sel_i = 0, s;
  logic [31:0] wb_dat_i = 0, periph_out = 0, periph_oe = 0, ext_en = 0;
  logic [31:0] ext_val = 0, mo, di, pu, dq, rd, d, em, ep, lk;
  wire [31:0] wb_dat_o, pad_in, pad_out, pad_oe_n, pad_pull_up;
  wire [31:0] pad_pull_down, periph_in;
  wire wb_ack_o, external_clear_pin_n, muxed_bus_addr_drive;
  wire sync_ready_internal, core_reset, fetch_enable, fetch_start;
  wire [19:0] reset_vector;
  int n_errors = 0, samples_checked = 0, seed = 32'h9b0c, cyc_n = 0;
  always #5 clk = ~clk;
  pio_mux_reset_straps i_pio_mux_reset_straps (.clk, .rst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
    .wb_ack_o, .external_clear_pin_n, .address_enable_strap, .pad_in,
    .pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_down, .periph_out,
    .periph_oe, .periph_in, .addr_phase, .lower_memory_select,
    .upper_memory_select, .muxed_bus_addr_drive, .sync_ready_input,
    .sync_ready_internal, .core_reset, .fetch_enable, .fetch_start,
    .reset_vector);
  board_model i_board_model (.clk, .hold_req(hold), .ext_en, .ext_val,
    .pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_down,
    .external_clear_pin_n, .pad_in);
  // hang guard
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // one classic cycle, held until ack sampled high
  task automatic wb(logic w, logic [7:0] ad, logic [31:0] dt, logic [3:0] sl_);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= ad;
    wb_dat_i <= dt;
    wb_sel_i <= sl_;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] mrg(logic [31:0] o, n, logic [3:0] b);
    for (int i = 0; i < 4; i++) if (b[i]) o[8*i+:8] = n[8*i+:8];
    return o;
  endfunction
  // pad outputs against the model
  task automatic pads();
    lk = sl ? 32'hFFFF_FFFF : ~32'h2400_0000;
    em = mo & lk;
    ep = (pu & ~32'h0000_0040) | 32'h0000_03B0;
    d = (em & ~di) | (~em & ~periph_oe);
    chk("oe_n", d, pad_oe_n);
    chk("out", ((em & dq) | (~em & periph_out)) & ~d, pad_out & ~d);
    chk("up", em & ~di & ep, pad_pull_up);
    chk("dn", em & ~di & ~ep, pad_pull_down);
    chk("rdy", sync_ready_input & ~em[6], sync_ready_internal);
  endtask
  // pin reset with a given strap, then model reset values
  task automatic boot(logic st);
    address_enable_strap <= st;
    hold <= 1;
    @(posedge clk);
    hold <= 0;
    repeat (4) @(posedge clk);
    while (fetch_enable !== 1'b1) @(posedge clk);
    {mo, di, pu, dq, sl} = {~32'h0000_03F0, 32'h0, ~32'h00C0_0402, 32'h0, st};
    pads();
    wb(0, 8'h18, 0, 4'hF);
    chk("status", {29'h0, 1'b1, st, 1'b1}, rd & 7);
    wb(0, 8'h00, 0, 4'hF);
    chk("mode", mo & lk, rd);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    // let the pin synchroniser leave reset before the first pin pulse
    while (fetch_enable !== 1'b1) @(posedge clk);
    boot(1);
    $display("test reset done");
    repeat (60) begin
      periph_out <= $random(seed);
      periph_oe <= $random(seed);
      ext_en <= $random(seed);
      ext_val <= $random(seed) ^ cyc_n;
      sync_ready_input <= 1'($random(seed));
      a = 8'(8'h04 * ({$random(seed)} % 4));
      d = $random(seed);
      s = 4'($random(seed));
      wb(1, a, d, s);
      case (a)
        8'h00: mo = mrg(mo, d, s);
        8'h04: di = mrg(di, d, s);
        8'h08: pu = mrg(pu, d, s);
        default: dq = mrg(dq, d, s);
      endcase
      pads();
      wb(0, a, 0, 4'hF);
      chk("readback", a == 0 ? em : a == 4 ? di & lk : a == 8 ? ep : dq, rd);
      chk("periph_in", pad_in, periph_in);
      // pad levels as the input register takes them one edge before the request edge
      d = pad_in;
      wb(0, 8'h10, 0, 4'hF);
      chk("pins", d, rd);
    end
    wb(1, 8'h40, 32'hFFFF_FFFF, 4'hF);
    wb(0, 8'h40, 0, 4'hF);
    chk("unmapped", 0, rd);
    $display("test random done");
    wb(1, 8'h14, 3, 4'h1);
    addr_phase <= 1;
    lower_memory_select <= 1;
    address_enable_strap <= 0;
    repeat (2) @(posedge clk);
    chk("gate", 0, muxed_bus_addr_drive);
    wb(0, 8'h18, 0, 4'hF);
    chk("latched", 3'h7, rd & 7);
    // lower gate off, upper gate on
    wb(1, 8'h14, 32'h0000_0002, 4'h1);
    chk("lower_open", 1, muxed_bus_addr_drive);
    lower_memory_select <= 0;
    upper_memory_select <= 1;
    repeat (2) @(posedge clk);
    chk("upper_gate", 0, muxed_bus_addr_drive);
    lower_memory_select <= 1;
    upper_memory_select <= 0;
    addr_phase <= 0;
    boot(0);
    wb(1, 8'h00, 32'hFFFF_FFFF, 4'hF);
    wb(1, 8'h04, 32'hFFFF_FFFF, 4'hF);
    {mo, di} = {64{1'b1}};
    pads();
    wb(0, 8'h00, 0, 4'hF);
    chk("locked", ~32'h2400_0000, rd);
    wb(1, 8'h14, 3, 4'h1);
    wb(0, 8'h14, 0, 4'hF);
    chk("region", 0, rd & 3);
    addr_phase <= 1;
    repeat (2) @(posedge clk);
    chk("ungated", 1, muxed_bus_addr_drive);
    $display("test strap done");
    summarize();
  end
endmodule // tb
`default_nettype wire
